/* swd_edge_detect.sv */
// One wake input detector: level or edge qualification of a pin sample.
// Assumes the pin is already synchronous to clk_sys_i.
`timescale 1ns/1ps
module swd_edge_detect
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    // Pin and configuration
    input  wire logic          pin_i,
    input  wire swd_chan_cfg_t cfg_i,
    // Detection results
    output logic               req_o,
    output swd_edge_t          edge_o
);

    logic prev_q;
    logic primed_q;
    logic rise;
    logic fall;
    logic hit;

    // Previous sample; no edge is taken before one real sample exists,
    // so a pin that sits high at reset release does not fake a rising edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q   <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= pin_i;
            primed_q <= 1'b1;
        end
    end

    assign rise = primed_q & pin_i & ~prev_q;
    assign fall = primed_q & ~pin_i & prev_q;

    always_comb begin
        hit = 1'b0;
        unique case (cfg_i.sel)
            SWD_DET_LOW:  hit = ~pin_i;
            SWD_DET_HIGH: hit = pin_i;
            SWD_DET_FALL: hit = fall;
            SWD_DET_RISE: hit = rise;
            SWD_DET_BOTH: hit = rise | fall;
            default:      hit = 1'b0; // Forbidden codes detect nothing
        endcase
    end

    assign req_o       = cfg_i.en & hit;
    assign edge_o.rise = cfg_i.en & (cfg_i.sel == SWD_DET_BOTH) & rise;
    assign edge_o.fall = cfg_i.en & (cfg_i.sel == SWD_DET_BOTH) & fall;

endmodule // swd_edge_detect

/* swd_pkg.sv */
// Shared constants and types for the standby wake request detector.
// Assumes a single 25 MHz system clock domain and a plain strobe register port.
package swd_pkg;

    // Geometry
    localparam int          SWD_NUM_CH      = 4;
    localparam int          SWD_ADDR_W      = 8;
    localparam int          SWD_DATA_W      = 32;

    // Register byte addresses
    localparam logic [7:0]  SWD_ADDR_MODE   = 8'h00;
    localparam logic [7:0]  SWD_ADDR_CLEAR  = 8'h04;
    localparam logic [7:0]  SWD_ADDR_MASK   = 8'h08;

    // Per-channel field layout inside the mode control word
    localparam int          SWD_CH_STRIDE   = 8;
    localparam int          SWD_SEL_OFS     = 4;
    localparam int          SWD_SEL_W       = 3;
    localparam int          SWD_STAT_OFS    = 2;
    localparam int          SWD_STAT_W      = 2;
    localparam int          SWD_EN_OFS      = 0;

    // Reset values
    localparam logic [2:0]  SWD_SEL_RST     = 3'h1;
    localparam logic [1:0]  SWD_STAT_RST    = 2'h0;
    localparam logic        SWD_EN_RST      = 1'b0;
    localparam logic [3:0]  SWD_VEC_RST     = 4'h0;
    localparam logic [31:0] SWD_WORD_ZERO   = 32'h0000_0000;

    // Detection select codes; 3'h5 to 3'h7 are not legal settings
    typedef enum logic [2:0] {
        SWD_DET_LOW  = 3'b000,
        SWD_DET_HIGH = 3'b001,
        SWD_DET_FALL = 3'b010,
        SWD_DET_RISE = 3'b011,
        SWD_DET_BOTH = 3'b100
    } swd_detect_t;

    // Edge record: 2'h1 rising, 2'h2 falling, 2'h3 both
    typedef struct packed {
        logic fall;
        logic rise;
    } swd_edge_t;

    // Channel configuration as held in the mode control word
    typedef struct packed {
        swd_detect_t sel;
        logic        en;
    } swd_chan_cfg_t;

endpackage : swd_pkg

/* swd_wake_chk.sv */
// Port checker for the wake request detector.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/1ps
module swd_wake_chk
    import swd_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys_i,
    input wire logic                  rst_n_i,
    // Register port
    input wire logic [SWD_ADDR_W-1:0] reg_addr_i,
    input wire logic [SWD_DATA_W-1:0] reg_wdata_i,
    input wire logic                  reg_wr_i,
    input wire logic                  reg_rd_i,
    input wire logic [SWD_DATA_W-1:0] reg_rdata_o,
    // Pins and requests
    input wire logic                  ext_wake_input_0_i,
    input wire logic                  ext_wake_input_1_i,
    input wire logic                  ext_wake_input_3_i,
    input wire logic [SWD_NUM_CH-1:0] wake_req_o,
    input wire logic                  irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic [31:0] mode_q;
    logic [3:0]  mask_q;
    logic        rd_mode;
    logic        wr_clr;
    // Shadow of software writes; status bits are masked off where used
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= 32'h1010_1010;
            mask_q <= 4'h0;
        end else if (reg_wr_i && reg_addr_i == SWD_ADDR_MODE) begin
            mode_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == SWD_ADDR_MASK) begin
            mask_q <= reg_wdata_i[3:0];
        end
    end
    assign rd_mode = reg_rd_i && reg_addr_i == SWD_ADDR_MODE;
    assign wr_clr  = reg_wr_i && reg_addr_i == SWD_ADDR_CLEAR && reg_wdata_i[0];
    property p_rsvd; $past(rd_mode) |-> (reg_rdata_o & 32'h8282_8282) == 32'h0; endproperty
    property p_mode; $past(rd_mode) |-> (reg_rdata_o & 32'h7171_7171) == ($past(mode_q) & 32'h7171_7171);
    endproperty
    property p_en; (wake_req_o & ~$past(wake_req_o)
        & ~$past({mode_q[24], mode_q[16], mode_q[8], mode_q[0]})) == 4'h0; endproperty
    property p_high; $past(mode_q[14:12] == 3'h1 && mode_q[8] && ext_wake_input_1_i) |-> wake_req_o[1];
    endproperty
    property p_low; $past(mode_q[6:4] == 3'h0 && mode_q[0] && !ext_wake_input_0_i) |-> wake_req_o[0];
    endproperty
    property p_rise; $past(mode_q[30:28] == 3'h3 && mode_q[24]) && $past(ext_wake_input_3_i)
        && !$past(ext_wake_input_3_i, 2) |-> wake_req_o[3]; endproperty
    property p_clr; $past(wr_clr && !mode_q[0]) |-> !wake_req_o[0]; endproperty
    property p_irq; irq_o == |(wake_req_o & mask_q); endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
    a_mode: assert property (p_mode) else $error("mode word readback wrong");
    a_en: assert property (p_en) else $error("request from disabled input");
    a_high: assert property (p_high) else $error("high level missed");
    a_low: assert property (p_low) else $error("low level missed");
    a_rise: assert property (p_rise) else $error("rising edge missed");
    a_clr: assert property (p_clr) else $error("clear did not drop request");
    a_irq: assert property (p_irq) else $error("irq level wrong");
    c_all: cover property (wake_req_o == 4'hf);
    c_irq: cover property (irq_o);
    c_both: cover property ($past(rd_mode) && reg_rdata_o[3:2] == 2'h3);
endmodule // swd_wake_chk

bind swd_wake_detect swd_wake_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ext_wake_input_0_i(ext_wake_input_0_i), .ext_wake_input_1_i(ext_wake_input_1_i),
    .ext_wake_input_3_i(ext_wake_input_3_i), .wake_req_o(wake_req_o), .irq_o(irq_o));

/* swd_wake_detect.sv */
// Standby wake request detector for four external inputs, with its registers.
// Assumes pins synchronous to clk_sys_i and a master that never overlaps strobes.
//
// Behaviour
// - Select field codes 000..100 mean low, high, falling, rising, both edges.
// - Read-only 2-bit edge status: 00 none, 01 rising, 10 falling, 11 both.
// - Edge status has content only while select holds the both-edges code.
// - Edge status records which active edge caused the wake request.
// - Clearing a channel's pending request also clears its edge status.
// - Per-channel enable at bits 24,16,8,0; zero blocks, one passes input.
// - Select and status fields sit in each channel's byte lane.
`timescale 1ns/1ps
module swd_wake_detect
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    // Register port
    input  wire logic [SWD_ADDR_W-1:0] reg_addr_i,
    input  wire logic [SWD_DATA_W-1:0] reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [SWD_DATA_W-1:0] reg_rdata_o,
    // External wake inputs
    input  wire logic                  ext_wake_input_0_i,
    input  wire logic                  ext_wake_input_1_i,
    input  wire logic                  ext_wake_input_2_i,
    input  wire logic                  ext_wake_input_3_i,
    // Requests toward the clock generator and the core
    output logic      [SWD_NUM_CH-1:0] wake_req_o,
    output logic                       irq_o
);

    // Configuration and state
    swd_chan_cfg_t                     cfg_q   [SWD_NUM_CH];
    swd_edge_t                         edge_q  [SWD_NUM_CH];
    logic          [SWD_NUM_CH-1:0]    pend_q;
    logic          [SWD_NUM_CH-1:0]    mask_q;
    logic          [SWD_DATA_W-1:0]    rdata_q;

    // Detector results
    logic          [SWD_NUM_CH-1:0]    pins;
    logic          [SWD_NUM_CH-1:0]    req;
    swd_edge_t                         det_edge [SWD_NUM_CH];

    // Decoded accesses
    logic                              wr_mode;
    logic                              wr_clear;
    logic                              wr_mask;
    logic          [SWD_NUM_CH-1:0]    clr_bits;
    logic          [SWD_DATA_W-1:0]    mode_word;
    logic          [SWD_DATA_W-1:0]    rd_mux;

    assign pins = {ext_wake_input_3_i,
                   ext_wake_input_2_i,
                   ext_wake_input_1_i,
                   ext_wake_input_0_i};

    assign wr_mode  = reg_wr_i & (reg_addr_i == SWD_ADDR_MODE);
    assign wr_clear = reg_wr_i & (reg_addr_i == SWD_ADDR_CLEAR);
    assign wr_mask  = reg_wr_i & (reg_addr_i == SWD_ADDR_MASK);
    assign clr_bits = wr_clear ? reg_wdata_i[SWD_NUM_CH-1:0] : SWD_VEC_RST;

    generate
        for (genvar ch = 0; ch < SWD_NUM_CH; ch++) begin : g_ch
            localparam int SEL_LSB  = ch * SWD_CH_STRIDE + SWD_SEL_OFS;
            localparam int STAT_LSB = ch * SWD_CH_STRIDE + SWD_STAT_OFS;
            localparam int EN_BIT   = ch * SWD_CH_STRIDE + SWD_EN_OFS;
            localparam int LANE_LSB = ch * SWD_CH_STRIDE;

            logic [SWD_STAT_W-1:0] stat_view;

            swd_edge_detect u_det (
                .clk_sys_i (clk_sys_i),
                .rst_n_i   (rst_n_i),
                .pin_i     (pins[ch]),
                .cfg_i     (cfg_q[ch]),
                .req_o     (req[ch]),
                .edge_o    (det_edge[ch])
            );

            // Only writable fields are stored; reserved bits have no flops
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cfg_q[ch].sel <= swd_detect_t'(SWD_SEL_RST);
                    cfg_q[ch].en  <= SWD_EN_RST;
                end else if (wr_mode) begin
                    // Both fields take the write as given; ordering them is software's job
                    cfg_q[ch].sel <= swd_detect_t'(reg_wdata_i[SEL_LSB +: SWD_SEL_W]);
                    cfg_q[ch].en  <= reg_wdata_i[EN_BIT];
                end
            end

            // Edge record accumulates; a new edge beats a clear in the same cycle
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    edge_q[ch] <= swd_edge_t'(SWD_STAT_RST);
                end else begin
                    if (clr_bits[ch]) begin
                        edge_q[ch] <= det_edge[ch];
                    end else begin
                        edge_q[ch].rise <= edge_q[ch].rise | det_edge[ch].rise;
                        edge_q[ch].fall <= edge_q[ch].fall | det_edge[ch].fall;
                    end
                end
            end

            // Status is shown only in both-edges mode; stale content stays hidden
            assign stat_view = (cfg_q[ch].sel == SWD_DET_BOTH) ? edge_q[ch] : SWD_STAT_RST;

            // Lane layout: each lane drives only its own bits, so no two processes drive the same bit
            assign mode_word[LANE_LSB + SWD_CH_STRIDE - 1] = 1'b0;
            assign mode_word[SEL_LSB +: SWD_SEL_W]         = cfg_q[ch].sel;
            assign mode_word[STAT_LSB +: SWD_STAT_W]       = stat_view;
            assign mode_word[STAT_LSB - 1]                 = 1'b0;
            assign mode_word[EN_BIT]                       = cfg_q[ch].en;
        end
    endgenerate

    // Pending requests: sticky, write one to clear, set wins over clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= SWD_VEC_RST;
        end else begin
            pend_q <= (pend_q & ~clr_bits) | req;
        end
    end

    // Interrupt mask, same layout as the pending bits
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_q <= SWD_VEC_RST;
        end else if (wr_mask) begin
            mask_q <= reg_wdata_i[SWD_NUM_CH-1:0];
        end
    end

    // Read mux; unmapped addresses return zero
    always_comb begin
        rd_mux = SWD_WORD_ZERO;
        unique case (reg_addr_i)
            SWD_ADDR_MODE:  rd_mux = mode_word;
            SWD_ADDR_CLEAR: rd_mux[SWD_NUM_CH-1:0] = pend_q;
            SWD_ADDR_MASK:  rd_mux[SWD_NUM_CH-1:0] = mask_q;
            default:        rd_mux = SWD_WORD_ZERO;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= SWD_WORD_ZERO;
        end else if (reg_rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= SWD_WORD_ZERO;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign wake_req_o  = pend_q;
    assign irq_o       = |(pend_q & mask_q);

endmodule // swd_wake_detect

/* testbench.sv */
// Self-checking bench for the wake request detector.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
module testbench
    import swd_pkg::*;
;
    logic                  clk_sys_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic [SWD_ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [SWD_DATA_W-1:0] reg_wdata_i = 32'h0;
    logic                  reg_wr_i = 1'b0;
    logic                  reg_rd_i = 1'b0;
    logic [3:0]            pins = 4'h0;
    logic [SWD_DATA_W-1:0] reg_rdata_o;
    logic [SWD_NUM_CH-1:0] wake_req_o;
    logic                  irq_o;
    int                    n_mismatch = 0;
    int                    n_tests = 0;
    int                    cyc = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    swd_wake_detect dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ext_wake_input_0_i(pins[0]), .ext_wake_input_1_i(pins[1]), .ext_wake_input_2_i(pins[2]),
        .ext_wake_input_3_i(pins[3]), .wake_req_o(wake_req_o), .irq_o(irq_o));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // Two edges after a pin change let a detected edge reach the pending bit
    task automatic pin(input logic [3:0] v);
        @(posedge clk_sys_i);
        pins <= v;
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic end_sim;
        $display("Compared %0d, mismatched %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(SWD_ADDR_MODE, 32'h1010_1010);
        rd(8'h0c, 32'h0);
        wr(SWD_ADDR_MODE, 32'h8e8e_8e8e);
        rd(SWD_ADDR_MODE, 32'h0);
        pin(4'b0101);
        wr(SWD_ADDR_MODE, 32'h3020_1000);
        pin(4'b1010);
        rd(SWD_ADDR_CLEAR, 32'h0);
        pin(4'b0101);
        wr(SWD_ADDR_MODE, 32'h3121_1101);
        rd(SWD_ADDR_MODE, 32'h3121_1101);
        rd(SWD_ADDR_CLEAR, 32'h0);
        pin(4'b1010);
        rd(SWD_ADDR_CLEAR, 32'hf);
        chk({28'h0, wake_req_o}, 32'hf);
        chk({31'h0, irq_o}, 32'h0);
        wr(SWD_ADDR_MASK, 32'h4);
        chk({31'h0, irq_o}, 32'h1);
        wr(SWD_ADDR_MODE, 32'h3020_1000);
        wr(SWD_ADDR_CLEAR, 32'hf);
        rd(SWD_ADDR_CLEAR, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(SWD_ADDR_MODE, 32'h40);
        wr(SWD_ADDR_MODE, 32'h41);
        pin(4'b1011);
        rd(SWD_ADDR_MODE, 32'h45);
        pin(4'b1010);
        rd(SWD_ADDR_MODE, 32'h4d);
        wr(SWD_ADDR_CLEAR, 32'h1);
        rd(SWD_ADDR_MODE, 32'h41);
        pin(4'b1011);
        wr(SWD_ADDR_CLEAR, 32'h1);
        pin(4'b1010);
        rd(SWD_ADDR_MODE, 32'h49);
        wr(SWD_ADDR_MODE, 32'h31);
        rd(SWD_ADDR_MODE, 32'h31);
        end_sim;
    end
endmodule // testbench
